// ==== design/lcdcm_pkg.sv ====
package lcdcm_pkg;

  // Register addresses on the special-function-register bus.
  localparam logic [7:0] LCDCM_CONTRAST_ADDR = 8'h9c;
  localparam logic [7:0] LCDCM_MASTER_ADDR = 8'hab;

  // Contrast setpoint field layout.
  localparam int LCDCM_CODE_MSB = 4;
  localparam int LCDCM_CODE_W = 5;
  localparam logic [7:0] LCDCM_CONTRAST_MASK = 8'h1f;
  localparam logic [4:0] LCDCM_CONTRAST_RESET = 5'h00;

  // Master control bit positions for the upper half.
  localparam int LCDCM_BIAS_BIT = 6;
  localparam int LCDCM_CONV_BIAS_BIT = 5;
  localparam int LCDCM_CLK_GATE_BIT = 4;
  localparam logic [7:0] LCDCM_MASTER_MASK = 8'h70;

  // Values after reset of the master control bits.
  localparam logic LCDCM_BIAS_RESET = 1'b0;
  localparam logic LCDCM_CONV_BIAS_RESET = 1'b1;
  localparam logic LCDCM_CLK_GATE_RESET = 1'b0;

  // Nominal drive-supply target: base, top and step in millivolts.
  localparam int LCDCM_DISPLAY_DRIVE_SUPPLY_BASE_MV = 1900;
  localparam int LCDCM_DISPLAY_DRIVE_SUPPLY_TOP_MV = 3720;
  localparam int LCDCM_DISPLAY_DRIVE_SUPPLY_STEP_MV = 60;

  // Static control levels sent to the analog side and the clock gates.
  typedef struct packed {
    logic [4:0] contrast_code;
    logic display_bias_on;
    logic converter_bias_output_on;
    logic display_clock_gate_on;
  } lcdcm_ctrl_t;

  // Register-bus request.
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } lcdcm_req_t;

endpackage : lcdcm_pkg

// ==== design/lcdcm_regs.sv ====
`timescale 1ns/1ps
// What this block does
// - Bits 7:5 of the contrast setpoint register always read zero and software writes zero there.
// - Bits 4:0 of the contrast setpoint register are a five-bit code from 1.90 V at zero to 3.72 V at all ones.
// - Each step of the contrast code raises the target drive voltage by about 59 mV.
// - Bit 7 of the master control register always reads zero and software writes zero there.
// - Bit 6 of the master control register disables the display bias at 0 and enables it at 1.
// - Bit 5 of the master control register gates off the converter bias at 0 and supplies it at 1.
// - Bit 4 of the master control register gates off the display clock at 0 and passes it undivided at 1.
module lcdcm_regs (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Register bus.
  input wire lcdcm_pkg::lcdcm_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  // Static control outputs.
  output lcdcm_pkg::lcdcm_ctrl_t ctrl
);
  import lcdcm_pkg::*;

  // True when a strobe is raised for the given register address.
  function automatic logic lcdcm_hit(input logic strobe, input logic [7:0] addr, input logic [7:0] reg_addr);
    lcdcm_hit = strobe && (addr == reg_addr);
  endfunction : lcdcm_hit

  function automatic logic [7:0] lcdcm_contrast_image(input logic [4:0] code);
    lcdcm_contrast_image = {3'h0, code} & LCDCM_CONTRAST_MASK;
  endfunction : lcdcm_contrast_image

  function automatic logic [7:0] lcdcm_master_image(input lcdcm_ctrl_t levels);
    logic [7:0] image;
    image = 8'h00;
    image[LCDCM_BIAS_BIT] = levels.display_bias_on;
    image[LCDCM_CONV_BIAS_BIT] = levels.converter_bias_output_on;
    image[LCDCM_CLK_GATE_BIT] = levels.display_clock_gate_on;
    lcdcm_master_image = image & LCDCM_MASTER_MASK;
  endfunction : lcdcm_master_image

  // Target voltage in millivolts for a code, rounded to the nearest millivolt.
  function automatic int lcdcm_target_mv(input logic [4:0] code);
    int span;
    span = LCDCM_DISPLAY_DRIVE_SUPPLY_TOP_MV - LCDCM_DISPLAY_DRIVE_SUPPLY_BASE_MV;
    lcdcm_target_mv = LCDCM_DISPLAY_DRIVE_SUPPLY_BASE_MV + (span * int'(code) + 15) / 31;
  endfunction : lcdcm_target_mv

  // Decoded strobes of this cycle.
  logic wr_contrast;
  logic wr_master;
  logic rd_contrast;
  logic rd_master;

  // Control level group.
  lcdcm_ctrl_t next_ctrl;

  // Read return group.
  logic [7:0] next_rdata;
  logic next_rvalid;

  // Nominal drive target, kept inside the block for observation only.
  logic [15:0] target_mv;
  logic [15:0] next_target_mv;

  always_comb begin
    wr_contrast = lcdcm_hit(req.wr, req.addr, LCDCM_CONTRAST_ADDR);
    wr_master = lcdcm_hit(req.wr, req.addr, LCDCM_MASTER_ADDR);
    rd_contrast = lcdcm_hit(req.rd, req.addr, LCDCM_CONTRAST_ADDR);
    rd_master = lcdcm_hit(req.rd, req.addr, LCDCM_MASTER_ADDR);
  end

  // Control levels: reset wins, then each register takes only its own fields.
  always_comb begin
    next_ctrl = ctrl;
    if (srst) begin
      next_ctrl.contrast_code = LCDCM_CONTRAST_RESET;
      next_ctrl.display_bias_on = LCDCM_BIAS_RESET;
      next_ctrl.converter_bias_output_on = LCDCM_CONV_BIAS_RESET;
      next_ctrl.display_clock_gate_on = LCDCM_CLK_GATE_RESET;
    end else begin
      if (wr_contrast) begin
        next_ctrl.contrast_code = req.wdata[LCDCM_CODE_MSB:0];
      end
      if (wr_master) begin
        next_ctrl.display_bias_on = req.wdata[LCDCM_BIAS_BIT];
        next_ctrl.converter_bias_output_on = req.wdata[LCDCM_CONV_BIAS_BIT];
        next_ctrl.display_clock_gate_on = req.wdata[LCDCM_CLK_GATE_BIT];
      end
    end
  end

  always_ff @(posedge clk) begin
    ctrl <= next_ctrl;
  end

  // Read data is taken from the levels before any write of the same cycle.
  always_comb begin
    next_rdata = 8'h00;
    next_rvalid = 1'b0;
    if (!srst) begin
      next_rvalid = req.rd;
      if (rd_contrast) begin
        next_rdata = lcdcm_contrast_image(ctrl.contrast_code);
      end else if (rd_master) begin
        next_rdata = lcdcm_master_image(ctrl);
      end
    end
  end

  always_ff @(posedge clk) begin
    rdata <= next_rdata;
    rvalid <= next_rvalid;
  end

  always_comb begin
    next_target_mv = 16'(LCDCM_DISPLAY_DRIVE_SUPPLY_BASE_MV);
    if (!srst) begin
      next_target_mv = 16'(lcdcm_target_mv(next_ctrl.contrast_code));
    end
  end

  always_ff @(posedge clk) begin
    target_mv <= next_target_mv;
  end

endmodule : lcdcm_regs

// ==== verif/lcdcm_regs_properties.sv ====
`timescale 1ns/1ps
module lcdcm_regs_properties (
  input wire logic clk,
  input wire logic srst,
  input wire lcdcm_pkg::lcdcm_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire lcdcm_pkg::lcdcm_ctrl_t ctrl
);
  import lcdcm_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire wc = req.wr && req.addr == LCDCM_CONTRAST_ADDR;
  wire wm = req.wr && req.addr == LCDCM_MASTER_ADDR;
  a_read_answer: assert property (req.rd |=> rvalid) else $error("no answer");
  a_idle_quiet: assert property (!req.rd |=> !rvalid && rdata == 8'h00) else $error("stray data");
  a_code_write: assert property (wc |=> ctrl.contrast_code == $past(req.wdata[4:0])) else $error("code");
  a_contrast_rsv: assert property (req.rd && !req.addr[1] |=> rdata[7:5] == 3'h0) else $error("rsv");
  a_master_rsv: assert property (req.rd |=> !rdata[7]) else $error("bit 7");
  a_bias_write: assert property (wm |=> ctrl.display_bias_on == $past(req.wdata[6])) else $error("bias");
  a_conv_write: assert property (wm |=> ctrl.converter_bias_output_on == $past(req.wdata[5])) else $error("dc");
  a_gate_write: assert property (wm |=> ctrl.display_clock_gate_on == $past(req.wdata[4])) else $error("gate");
  a_ctrl_hold: assert property (!req.wr |=> $stable(ctrl)) else $error("ctrl moved");
endmodule : lcdcm_regs_properties
bind lcdcm_regs lcdcm_regs_properties u_props (.clk(clk), .srst(srst), .req(req), .rdata(rdata),
  .rvalid(rvalid), .ctrl(ctrl));

// ==== verif/lcdcm_regs_bench.sv ====
`timescale 1ns/1ps
module lcdcm_regs_bench;
  import lcdcm_pkg::*;
  logic clk = 0;
  logic srst = 1;
  lcdcm_req_t req = '0;
  logic [7:0] rdata;
  logic rvalid;
  lcdcm_ctrl_t ctrl;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  lcdcm_regs dut (.clk(clk), .srst(srst), .req(req), .rdata(rdata), .rvalid(rvalid), .ctrl(ctrl));
  always #10 clk = ~clk;
  task finish_test;
    if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  task chk(input logic [8:0] got, input logic [8:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %h vs %h", $time, got, exp);
    end
  endtask : chk
  // One bus cycle; a read is checked in the cycle after it is taken.
  task acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    req = '{a, w, r, d};
    @(negedge clk);
    if (r) chk({rvalid, rdata}, {1'b1, e});
  endtask : acc
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      miscompares++;
      finish_test;
    end
  end
  initial begin
    repeat (2) @(negedge clk);
    srst = 0;
    chk({1'b0, ctrl}, 9'h002);
    chk({rvalid, rdata}, 9'h000);
    acc(1'b0, 1'b1, LCDCM_MASTER_ADDR, 8'h00, 8'h20);
    for (int i = 0; i < 32; i++) begin
      acc(1'b1, 1'b0, LCDCM_CONTRAST_ADDR, i[7:0], 8'h00);
      acc(1'b0, 1'b1, LCDCM_CONTRAST_ADDR, 8'h00, i[7:0]);
      chk({4'h0, ctrl.contrast_code}, {4'h0, i[4:0]});
    end
    acc(1'b1, 1'b1, LCDCM_CONTRAST_ADDR, 8'h05, 8'h1f);
    acc(1'b1, 1'b0, 8'h9d, 8'hff, 8'h00);
    acc(1'b0, 1'b1, 8'h9d, 8'h00, 8'h00);
    for (int i = 0; i < 8; i++) begin
      acc(1'b1, 1'b0, LCDCM_MASTER_ADDR, {1'b0, i[2:0], 4'hf}, 8'h00);
      acc(1'b0, 1'b1, LCDCM_MASTER_ADDR, 8'h00, {1'b0, i[2:0], 4'h0});
      chk({1'b0, ctrl}, {1'b0, 5'h05, i[2:0]});
    end
    req = '0;
    srst = 1;
    @(negedge clk);
    srst = 0;
    chk({1'b0, ctrl}, 9'h002);
    chk({rvalid, rdata}, 9'h000);
    finish_test;
  end
endmodule : lcdcm_regs_bench
